// File: clock_reset_pkg.sv
// constants and types shared by the clock and reset control
`default_nettype none
package clock_reset_pkg;
  localparam int unsigned SRC_COUNT       = 5;
  localparam int unsigned DIV_COUNT       = 12;
  localparam int unsigned FRAC_DIV_COUNT  = 2;
  localparam int unsigned PER_CLK_COUNT   = 16;
  localparam int unsigned INT_W           = 16;
  localparam int unsigned FRAC_W          = 5;
  localparam int unsigned SEL_W           = 4;

  typedef enum logic [2:0] {
    SRC_FAST_INT   = 3'h0,
    SRC_SLOW_INT   = 3'h1,
    SRC_FAST_XTAL  = 3'h2,
    SRC_WATCH_XTAL = 3'h3,
    SRC_PIN        = 3'h4
  } clk_src_t;

  typedef enum logic [1:0] {
    SW_RUN      = 2'h0,
    SW_DRAIN    = 2'h1,
    SW_WAIT_NEW = 2'h2
  } switch_state_t;

  localparam clk_src_t    SRC_RESET        = SRC_FAST_INT;
  localparam logic [1:0]  PRESCALE_RESET   = 2'h0;
  localparam logic [5:0]  FAST_OSC_MIN_MHZ = 6'h03;
  localparam logic [5:0]  FAST_OSC_MAX_MHZ = 6'h30;
  localparam logic [5:0]  FAST_OSC_RESET   = 6'h18;
  localparam int unsigned WDT_TIMEOUT_TICKS = 32768;
  localparam int unsigned WDT_RST_CYCLES   = 16;
  localparam int unsigned CAL_SLOW_PERIODS = 16;
  localparam int unsigned POR_SETTLE_CYCLES = 8;

  // reset cause bit positions
  localparam int unsigned CAUSE_WDT_BIT    = 0;
  localparam int unsigned CAUSE_BROWN_BIT  = 1;
  localparam int unsigned CAUSE_PIN_BIT    = 2;
  localparam int unsigned CAUSE_W          = 3;
endpackage : clock_reset_pkg
`default_nettype wire

// File: divider_if.sv
// control and output bundle of one clock divider
`default_nettype none
interface divider_if;
  logic                              tick;
  logic                              enable;
  logic [clock_reset_pkg::INT_W-1:0]  int_div;
  logic [clock_reset_pkg::FRAC_W-1:0] frac_div;
  logic                              pulse;
  modport ctrl (output tick, output enable, output int_div, output frac_div, input pulse);
  modport div  (input tick, input enable, input int_div, input frac_div, output pulse);
endinterface : divider_if
`default_nettype wire

// File: clock_divider.sv
// integer divider with optional fractional extension
`default_nettype none
module clock_divider #(
  parameter bit FRACTIONAL = 1'b0
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  divider_if.div   dif
);
  localparam int unsigned IW = clock_reset_pkg::INT_W;
  localparam int unsigned FW = clock_reset_pkg::FRAC_W;

  logic [IW-1:0] count;
  logic [FW-1:0] acc;
  logic          stretch;
  logic          pulse;
  logic [IW-1:0] next_count;
  logic [FW-1:0] next_acc;
  logic          next_stretch;
  logic          next_pulse;
  logic [FW:0]   sum;

  always_comb begin
    next_count   = count;
    next_acc     = acc;
    next_stretch = stretch;
    next_pulse   = 1'b0;
    sum          = {1'b0, acc} + {1'b0, dif.frac_div};
    if (!dif.enable) begin
      next_count   = '0;
      next_acc     = '0;
      next_stretch = 1'b0;
    end else if (dif.tick) begin
      if (count < dif.int_div) begin
        next_count = count + 1'b1;
      end else if (stretch) begin
        // fractional carry adds one extra root tick to this period
        next_stretch = 1'b0;
      end else begin
        next_count = '0;
        next_pulse = 1'b1;
        if (FRACTIONAL) begin
          next_acc     = sum[FW-1:0];
          next_stretch = sum[FW];
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count   <= '0;
      acc     <= '0;
      stretch <= 1'b0;
      pulse   <= 1'b0;
    end else begin
      count   <= next_count;
      acc     <= next_acc;
      stretch <= next_stretch;
      pulse   <= next_pulse;
    end
  end

  assign dif.pulse = pulse;
endmodule : clock_divider
`default_nettype wire

// File: system_clock_reset_control.sv
// clock source switching, dividers, watchdog and reset gathering
//
// Summary of operation
// - source changeover never makes glitches, runts or short pulses on the root clock.
// - sources are fast and slow internal, fast and watch crystal, and a pin.
// - twelve dividers feed sixteen divided peripheral clock outputs.
// - two dividers also divide by fractional ratios; the rest are integer only.
// - core clock and every peripheral clock come from dividing the root clock.
// - fast internal oscillator is set from 3 to 48 MHz in 1 MHz steps.
// - slow oscillator periods are measured in fast oscillator cycles for calibration.
// - fast crystal clocks the radio and may also be the system clock source.
// - watch crystal is the radio sleep clock and times wakeup intervals.
// - power-on hold keeps reset until supplies stable and clock ready.
// - brown-out detection resets the device while supply is too low.
// - supply drop below chosen threshold raises an interrupt, never a reset.
// - external reset pin low resets the device; undriven pin reads high.
// - watchdog counts slow oscillator, runs in deep sleep, resets on missed service.
// - watchdog reset is recorded in the readable reset cause bits.
`default_nettype none
module system_clock_reset_control #(
  parameter int unsigned WDT_TIMEOUT = clock_reset_pkg::WDT_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic                                clock_i,
  input  wire logic                                nrst_i,
  // oscillator levels from outside the clock domain
  input  wire logic                                fast_internal_oscillator_i,
  input  wire logic                                slow_internal_oscillator_i,
  input  wire logic                                fast_crystal_oscillator_i,
  input  wire logic                                watch_crystal_oscillator_i,
  input  wire logic                                pin_clock_input_i,
  // clock configuration
  input  wire logic [2:0]                          clk_src_sel_i,
  input  wire logic [1:0]                          core_prescale_i,
  input  wire logic [5:0]                          fast_osc_freq_mhz_i,
  input  wire logic [clock_reset_pkg::DIV_COUNT-1:0] div_enable_i,
  input  wire logic [clock_reset_pkg::DIV_COUNT*clock_reset_pkg::INT_W-1:0] div_int_i,
  input  wire logic [clock_reset_pkg::FRAC_DIV_COUNT*clock_reset_pkg::FRAC_W-1:0] div_frac_i,
  input  wire logic [clock_reset_pkg::PER_CLK_COUNT*clock_reset_pkg::SEL_W-1:0] per_sel_i,
  // clock outputs
  output logic                                     high_freq_root_clock_o,
  output logic                                     core_bus_clock_o,
  output logic [clock_reset_pkg::PER_CLK_COUNT-1:0] divided_peripheral_clock_o,
  output logic [5:0]                               fast_osc_freq_mhz_o,
  output logic [2:0]                               clk_src_active_o,
  output logic                                     clk_switching_o,
  // radio clocks and sleep timing
  output logic                                     radio_clock_o,
  output logic                                     low_freq_clock_o,
  input  wire logic                                sleep_timer_en_i,
  input  wire logic [15:0]                         sleep_interval_i,
  output logic                                     radio_wakeup_o,
  // calibration
  input  wire logic                                cal_start_i,
  output logic                                     cal_busy_o,
  output logic [23:0]                              cal_count_o,
  // supplies and resets
  input  wire logic                                supply_stable_i,
  input  wire logic                                clock_ready_i,
  input  wire logic                                brownout_detector_i,
  input  wire logic                                supply_below_thresh_i,
  input  wire logic [3:0]                          supply_thresh_sel_i,
  output logic [3:0]                               supply_thresh_o,
  input  wire logic                                supply_drop_ack_i,
  output logic                                     supply_drop_irq_o,
  input  wire logic                                external_reset_pin_n_i,
  // watchdog and reset cause
  input  wire logic                                wdt_enable_i,
  input  wire logic                                wdt_service_i,
  input  wire logic                                cause_clear_i,
  output logic [clock_reset_pkg::CAUSE_W-1:0]      reset_cause_o,
  output logic                                     system_reset_n_o
);
  localparam int unsigned NDIV = clock_reset_pkg::DIV_COUNT;
  localparam int unsigned NPER = clock_reset_pkg::PER_CLK_COUNT;
  localparam int unsigned IW   = clock_reset_pkg::INT_W;
  localparam int unsigned FW   = clock_reset_pkg::FRAC_W;
  localparam int unsigned SW   = clock_reset_pkg::SEL_W;

  // two-flop synchronisers for the oscillator, supply, brown-out and reset pin levels
  logic [9:0] meta;
  logic [9:0] sync;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 10'h200;
      sync <= 10'h200;
    end else begin
      meta <= {external_reset_pin_n_i, supply_below_thresh_i, brownout_detector_i,
               clock_ready_i, supply_stable_i, pin_clock_input_i,
               watch_crystal_oscillator_i, fast_crystal_oscillator_i,
               slow_internal_oscillator_i, fast_internal_oscillator_i};
      sync <= meta;
    end
  end
  wire logic [4:0] src_lvl = sync[4:0];
  wire logic       supply_ok = sync[5];
  wire logic       clk_ok    = sync[6];
  wire logic       brown     = sync[7];
  wire logic       below     = sync[8];
  wire logic       pin_n     = sync[9];

  // source level delayed one cycle for edge detection
  logic [4:0] src_prev;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) src_prev <= '0;
    else         src_prev <= src_lvl;
  end
  wire logic slow_rise  = src_lvl[clock_reset_pkg::SRC_SLOW_INT] &
                          ~src_prev[clock_reset_pkg::SRC_SLOW_INT];
  wire logic fast_rise  = src_lvl[clock_reset_pkg::SRC_FAST_INT] &
                          ~src_prev[clock_reset_pkg::SRC_FAST_INT];
  wire logic watch_rise = src_lvl[clock_reset_pkg::SRC_WATCH_XTAL] &
                          ~src_prev[clock_reset_pkg::SRC_WATCH_XTAL];

  // glitch-free source switch: park low on old source, resume on new low phase
  clock_reset_pkg::switch_state_t sw_state, next_sw_state;
  clock_reset_pkg::clk_src_t      cur_src, next_cur_src, pend_src, next_pend_src;
  logic                           root, next_root;
  logic [2:0]                     pre_cnt, next_pre_cnt;
  logic                           core, next_core;
  logic [5:0]                     freq, next_freq;
  logic                           root_tick;

  always_comb begin
    next_sw_state = sw_state;
    next_cur_src  = cur_src;
    next_pend_src = pend_src;
    next_root     = 1'b0;
    next_pre_cnt  = pre_cnt;
    next_core     = 1'b0;
    next_freq     = fast_osc_freq_mhz_i;
    case (sw_state)
      clock_reset_pkg::SW_RUN: begin
        next_root = src_lvl[cur_src];
        if (clk_src_sel_i != cur_src && clk_src_sel_i < 3'(clock_reset_pkg::SRC_COUNT)) begin
          next_pend_src = clock_reset_pkg::clk_src_t'(clk_src_sel_i);
          next_sw_state = clock_reset_pkg::SW_DRAIN;
        end
      end
      clock_reset_pkg::SW_DRAIN: begin
        // finish the high phase of the old source before parking low
        next_root = root & src_lvl[cur_src];
        if (!src_lvl[cur_src]) next_sw_state = clock_reset_pkg::SW_WAIT_NEW;
      end
      clock_reset_pkg::SW_WAIT_NEW: begin
        // join the new source only at its low phase, so no runt high
        if (!src_lvl[pend_src]) begin
          next_cur_src  = pend_src;
          next_sw_state = clock_reset_pkg::SW_RUN;
        end
      end
      default: next_sw_state = clock_reset_pkg::SW_RUN;
    endcase
    // tick made here so the next-state logic does not loop through a net
    root_tick = next_root & ~root;
    if (root_tick) begin
      // core clock: root divided by 2^n, n = 0..3
      next_pre_cnt = pre_cnt + 3'h1;
      next_core    = (pre_cnt & ~(3'h7 << core_prescale_i)) == 3'h0;
    end
    if (fast_osc_freq_mhz_i < clock_reset_pkg::FAST_OSC_MIN_MHZ)
      next_freq = clock_reset_pkg::FAST_OSC_MIN_MHZ;
    else if (fast_osc_freq_mhz_i > clock_reset_pkg::FAST_OSC_MAX_MHZ)
      next_freq = clock_reset_pkg::FAST_OSC_MAX_MHZ;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_state <= clock_reset_pkg::SW_RUN;
      cur_src  <= clock_reset_pkg::SRC_RESET;
      pend_src <= clock_reset_pkg::SRC_RESET;
      root     <= 1'b0;
      pre_cnt  <= 3'(clock_reset_pkg::PRESCALE_RESET);
      core     <= 1'b0;
      freq     <= clock_reset_pkg::FAST_OSC_RESET;
    end else begin
      sw_state <= next_sw_state;
      cur_src  <= next_cur_src;
      pend_src <= next_pend_src;
      root     <= next_root;
      pre_cnt  <= next_pre_cnt;
      core     <= next_core;
      freq     <= next_freq;
    end
  end

  // twelve dividers, the first two fractional
  divider_if dif [NDIV] ();
  logic [NDIV-1:0] div_pulse;
  for (genvar d = 0; d < NDIV; d++) begin : g_div
    assign dif[d].tick     = root_tick;
    assign dif[d].enable   = div_enable_i[d];
    assign dif[d].int_div  = div_int_i[d*IW +: IW];
    if (d < clock_reset_pkg::FRAC_DIV_COUNT) begin : g_frac
      assign dif[d].frac_div = div_frac_i[d*FW +: FW];
    end else begin : g_int
      assign dif[d].frac_div = '0;
    end
    assign div_pulse[d]    = dif[d].pulse;
    clock_divider #(
      .FRACTIONAL (d < clock_reset_pkg::FRAC_DIV_COUNT)
    ) u_div (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .dif     (dif[d])
    );
  end

  // sixteen outputs each pick one divider; out-of-range picks stay quiet
  logic [NPER-1:0] per, next_per;
  for (genvar p = 0; p < NPER; p++) begin : g_per
    wire logic [SW-1:0] sel = per_sel_i[p*SW +: SW];
    assign next_per[p] = (sel < SW'(NDIV)) ? div_pulse[sel] : 1'b0;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) per <= '0;
    else         per <= next_per;
  end

  // slow oscillator periods counted in fast oscillator edges
  logic        cal_busy, next_cal_busy;
  logic [4:0]  cal_per, next_cal_per;
  logic [23:0] cal_cnt, next_cal_cnt;
  // watch crystal sleep timer for radio wakeup
  logic [15:0] sleep_cnt, next_sleep_cnt;
  logic        wake, next_wake;
  always_comb begin
    next_cal_busy  = cal_busy;
    next_cal_per   = cal_per;
    next_cal_cnt   = cal_cnt;
    next_sleep_cnt = sleep_cnt;
    next_wake      = 1'b0;
    if (!cal_busy && cal_start_i) begin
      next_cal_busy = 1'b1;
      next_cal_per  = '0;
      next_cal_cnt  = '0;
    end else if (cal_busy) begin
      // count from the first slow edge on, so only whole periods are measured
      if (fast_rise && cal_per != 5'h0) next_cal_cnt = cal_cnt + 24'h1;
      if (slow_rise) begin
        next_cal_per = cal_per + 5'h1;
        if (cal_per == 5'(clock_reset_pkg::CAL_SLOW_PERIODS)) next_cal_busy = 1'b0;
      end
    end
    if (!sleep_timer_en_i) begin
      next_sleep_cnt = '0;
    end else if (watch_rise) begin
      if (sleep_cnt >= sleep_interval_i) begin
        next_sleep_cnt = '0;
        next_wake      = 1'b1;
      end else begin
        next_sleep_cnt = sleep_cnt + 16'h1;
      end
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_busy  <= 1'b0;
      cal_per   <= '0;
      cal_cnt   <= '0;
      sleep_cnt <= '0;
      wake      <= 1'b0;
    end else begin
      cal_busy  <= next_cal_busy;
      cal_per   <= next_cal_per;
      cal_cnt   <= next_cal_cnt;
      sleep_cnt <= next_sleep_cnt;
      wake      <= next_wake;
    end
  end

  // reset gathering, watchdog, supply drop flag
  logic [31:0]                       wdt_cnt, next_wdt_cnt;
  logic [4:0]                        wdt_hold, next_wdt_hold;
  logic [3:0]                        por_cnt, next_por_cnt;
  logic [clock_reset_pkg::CAUSE_W-1:0] cause, next_cause;
  logic                              drop_flag, next_drop_flag;
  logic                              sys_n, next_sys_n;
  logic [3:0]                        thresh;
  always_comb begin
    next_wdt_cnt   = wdt_cnt;
    next_wdt_hold  = (wdt_hold != 5'h0) ? wdt_hold - 5'h1 : 5'h0;
    next_por_cnt   = por_cnt;
    next_cause     = cause;
    next_drop_flag = drop_flag;
    // runs on slow oscillator edges only, so deep sleep does not stop it
    if (!wdt_enable_i || wdt_service_i) begin
      next_wdt_cnt = '0;
    end else if (slow_rise) begin
      if (wdt_cnt >= WDT_TIMEOUT - 1) begin
        next_wdt_cnt  = '0;
        next_wdt_hold = 5'(clock_reset_pkg::WDT_RST_CYCLES);
      end else begin
        next_wdt_cnt = wdt_cnt + 32'h1;
      end
    end
    // power-on hold waits for stable supply and ready clock
    if (!(supply_ok && clk_ok)) next_por_cnt = '0;
    else if (por_cnt != 4'(clock_reset_pkg::POR_SETTLE_CYCLES)) next_por_cnt = por_cnt + 4'h1;
    // clear first so a same-cycle event still lands
    if (cause_clear_i) next_cause = '0;
    if (next_wdt_hold == 5'(clock_reset_pkg::WDT_RST_CYCLES))
      next_cause[clock_reset_pkg::CAUSE_WDT_BIT] = 1'b1;
    if (brown) next_cause[clock_reset_pkg::CAUSE_BROWN_BIT] = 1'b1;
    if (!pin_n) next_cause[clock_reset_pkg::CAUSE_PIN_BIT] = 1'b1;
    if (supply_drop_ack_i) next_drop_flag = 1'b0;
    if (below) next_drop_flag = 1'b1;
    next_sys_n = (por_cnt == 4'(clock_reset_pkg::POR_SETTLE_CYCLES))
               & ~brown
               & pin_n
               & (wdt_hold == 5'h0);
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdt_cnt   <= '0;
      wdt_hold  <= '0;
      por_cnt   <= '0;
      cause     <= '0;
      drop_flag <= 1'b0;
      sys_n     <= 1'b0;
      thresh    <= '0;
    end else begin
      wdt_cnt   <= next_wdt_cnt;
      wdt_hold  <= next_wdt_hold;
      por_cnt   <= next_por_cnt;
      cause     <= next_cause;
      drop_flag <= next_drop_flag;
      sys_n     <= next_sys_n;
      thresh    <= supply_thresh_sel_i;
    end
  end

  assign high_freq_root_clock_o     = root;
  assign core_bus_clock_o           = core;
  assign divided_peripheral_clock_o = per;
  assign fast_osc_freq_mhz_o        = freq;
  assign clk_src_active_o           = cur_src;
  assign clk_switching_o            = (sw_state != clock_reset_pkg::SW_RUN);
  assign radio_clock_o              = src_lvl[clock_reset_pkg::SRC_FAST_XTAL];
  assign low_freq_clock_o           = src_lvl[clock_reset_pkg::SRC_WATCH_XTAL];
  assign radio_wakeup_o             = wake;
  assign cal_busy_o                 = cal_busy;
  assign cal_count_o                = cal_cnt;
  assign supply_thresh_o            = thresh;
  assign supply_drop_irq_o          = drop_flag;
  assign reset_cause_o              = cause;
  assign system_reset_n_o           = sys_n;
endmodule : system_clock_reset_control
`default_nettype wire

// File: scrc_asserts.sv
// concurrent checks on the clock and reset control ports
`default_nettype none
module scrc_asserts (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       nrst_i,
  // watched ports
  input wire logic [5:0] fast_osc_freq_mhz_i,
  input wire logic [5:0] fast_osc_freq_mhz_o,
  input wire logic [2:0] clk_src_active_o,
  input wire logic       clk_switching_o,
  input wire logic       high_freq_root_clock_o,
  input wire logic       external_reset_pin_n_i,
  input wire logic       brownout_detector_i,
  input wire logic       supply_stable_i,
  input wire logic       clock_ready_i,
  input wire logic       supply_drop_ack_i,
  input wire logic       supply_drop_irq_o,
  input wire logic [2:0] reset_cause_o,
  input wire logic       system_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  freq_range_a: assert property (fast_osc_freq_mhz_o inside {[6'h03:6'h30]})
    else $error("fast osc setting out of range");
  freq_track_a: assert property (fast_osc_freq_mhz_i inside {[6'h03:6'h30]}
    ##1 $stable(fast_osc_freq_mhz_i) |-> fast_osc_freq_mhz_o == fast_osc_freq_mhz_i)
    else $error("fast osc setting not followed");
  src_swap_a: assert property ($changed(clk_src_active_o) |->
    $past(clk_switching_o) && !$past(high_freq_root_clock_o)) else $error("unsafe swap");
  pin_rst_a: assert property (!external_reset_pin_n_i [*3] |=> !system_reset_n_o)
    else $error("pin low without reset");
  brown_rst_a: assert property (brownout_detector_i [*3] |=> !system_reset_n_o)
    else $error("brown-out without reset");
  por_gate_a: assert property ($rose(system_reset_n_o) |->
    $past(supply_stable_i, 3) && $past(clock_ready_i, 3)) else $error("early release");
  wdt_cause_a: assert property ($rose(reset_cause_o[0]) |=> !system_reset_n_o)
    else $error("watchdog cause without reset");
  irq_hold_a: assert property (supply_drop_irq_o && !supply_drop_ack_i |=>
    supply_drop_irq_o) else $error("irq dropped without ack");
  cover property ($fell(clk_switching_o));
  cover property ($rose(reset_cause_o[0]));
  cover property ($rose(supply_drop_irq_o));
endmodule : scrc_asserts
bind system_clock_reset_control scrc_asserts chk_u (.clock_i, .nrst_i, .fast_osc_freq_mhz_i,
  .fast_osc_freq_mhz_o, .clk_src_active_o, .clk_switching_o, .high_freq_root_clock_o,
  .external_reset_pin_n_i, .brownout_detector_i, .supply_stable_i, .clock_ready_i,
  .supply_drop_ack_i, .supply_drop_irq_o, .reset_cause_o, .system_reset_n_o);
`default_nettype wire

// File: osc_pin_model.sv
// far side: free-running oscillators and the reset pin
`default_nettype none
module osc_pin_model (
  // reset pin control
  input  wire logic pin_low_i,
  output logic      pin_n_o,
  // oscillator levels
  output logic      fast_int_o,
  output logic      slow_int_o,
  output logic      fast_xtal_o,
  output logic      watch_xtal_o,
  output logic      pin_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin floats to the pull-up level
  assign pin_n_o = !pin_low_i;
  initial begin
    {fast_int_o, slow_int_o, fast_xtal_o, watch_xtal_o, pin_clk_o} = 5'h00;
  end
  // periods unrelated to the sampling clock and all slower than it
  always #130 fast_int_o = !fast_int_o;
  always #770 slow_int_o = !slow_int_o;
  always #210 fast_xtal_o = !fast_xtal_o;
  always #1130 watch_xtal_o = !watch_xtal_o;
  always #330 pin_clk_o = !pin_clk_o;
endmodule : osc_pin_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for the clock and reset control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, nrst_i, pin_low, sstab, crdy, brown, below, ack, cal, wen, wsrv, cclr, slp;
  logic [2:0] sel;
  logic [1:0] pre;
  logic [5:0] mhz;
  logic [11:0] den;
  logic [191:0] dint;
  logic [3:0] thr;
  logic root_d;
  wire logic f_int, s_int, f_xt, w_xt, p_clk, pin_n, root, core, swg, busy, irq, srst_n, wake;
  wire logic [15:0] per;
  wire logic [5:0] mhz_o;
  wire logic [2:0] act, cause;
  wire logic [3:0] thr_o;
  wire logic [23:0] ccnt;
  int err_total = 0, checked = 0, n_root = 0, n_core = 0, n_per = 0, n_wake = 0, n_frc = 0;
  osc_pin_model far_u (.pin_low_i(pin_low), .pin_n_o(pin_n), .fast_int_o(f_int),
    .slow_int_o(s_int), .fast_xtal_o(f_xt), .watch_xtal_o(w_xt), .pin_clk_o(p_clk));
  system_clock_reset_control #(.WDT_TIMEOUT(8)) DUT (.clock_i, .nrst_i,
    .fast_internal_oscillator_i(f_int), .slow_internal_oscillator_i(s_int),
    .fast_crystal_oscillator_i(f_xt), .watch_crystal_oscillator_i(w_xt),
    .pin_clock_input_i(p_clk), .clk_src_sel_i(sel), .core_prescale_i(pre),
    .fast_osc_freq_mhz_i(mhz), .div_enable_i(den), .div_int_i(dint), .div_frac_i(10'h200),
    .per_sel_i(64'h1), .high_freq_root_clock_o(root), .core_bus_clock_o(core),
    .divided_peripheral_clock_o(per), .fast_osc_freq_mhz_o(mhz_o), .clk_src_active_o(act),
    .clk_switching_o(swg), .radio_clock_o(), .low_freq_clock_o(), .sleep_timer_en_i(slp),
    .sleep_interval_i(16'h0001), .radio_wakeup_o(wake), .cal_start_i(cal), .cal_busy_o(busy),
    .cal_count_o(ccnt), .supply_stable_i(sstab), .clock_ready_i(crdy),
    .brownout_detector_i(brown), .supply_below_thresh_i(below), .supply_thresh_sel_i(thr),
    .supply_thresh_o(thr_o), .supply_drop_ack_i(ack), .supply_drop_irq_o(irq),
    .external_reset_pin_n_i(pin_n), .wdt_enable_i(wen), .wdt_service_i(wsrv),
    .cause_clear_i(cclr), .reset_cause_o(cause), .system_reset_n_o(srst_n));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // running totals; scenarios take differences so no second driver is needed
  always @(posedge clock_i) begin
    root_d <= root;
    if (root && !root_d) n_root <= n_root + 1;
    n_core <= n_core + int'(core);
    n_per <= n_per + int'(per[15]);
    n_frc <= n_frc + int'(per[0]);
    n_wake <= n_wake + int'(wake);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic clear_cause;
    cclr <= 1'b1;
    cyc(1);
    cclr <= 1'b0;
    cyc(3);
  endtask : clear_cause
  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_por;
    chk({mhz_o, act, cause}, 12'h600);
    sstab <= 1'b1;
    cyc(20);
    chk(srst_n, 1'b0);
    crdy <= 1'b1;
    cyc(14);
    chk(srst_n, 1'b1);
  endtask : t_por
  task automatic t_freq;
    logic [5:0] req [6] = '{6'h02, 6'h03, 6'h30, 6'h31, 6'h00, 6'h11};
    logic [5:0] exp [6] = '{6'h03, 6'h03, 6'h30, 6'h30, 6'h03, 6'h11};
    for (int i = 0; i < 6; i++) begin
      mhz <= req[i];
      cyc(3);
      chk(mhz_o, exp[i]);
    end
  endtask : t_freq
  task automatic t_switch;
    logic [2:0] srcs [6] = '{3'h2, 3'h3, 3'h4, 3'h7, 3'h1, 3'h0};
    logic [2:0] want = 3'h0;
    for (int i = 0; i < 6; i++) begin
      want = (srcs[i] > 3'h4) ? want : srcs[i];
      sel <= srcs[i];
      cyc(2);
      chk(swg, srcs[i] < 3'h5);
      for (int k = 0; k < 200 && swg !== 1'b0; k++) cyc(1);
      cyc(2);
      chk(act, want);
    end
  endtask : t_switch
  task automatic t_clk;
    int r0, c0, p0, dr, w0, f0;
    pre <= 2'h3;
    den <= 12'h003;
    slp <= 1'b1;
    // core at root/8 stays faster than peripherals at root/16 and root/16.5
    dint[31:0] <= 32'h000F000F;
    cyc(40);
    r0 = n_root;
    c0 = n_core;
    p0 = n_per;
    w0 = n_wake;
    f0 = n_frc;
    cyc(4000);
    dr = n_root - r0;
    chk((n_core - c0) * 8 >= dr - 8 && (n_core - c0) * 8 <= dr + 8, 1'b1);
    chk((n_per - p0) * 16 >= dr - 16 && (n_per - p0) * 16 <= dr + 16, 1'b1);
    chk((n_frc - f0) * 33 >= dr * 2 - 36 && (n_frc - f0) * 33 <= dr * 2 + 36, 1'b1);
    chk((n_wake - w0) inside {[88:89]}, 1'b1);
  endtask : t_clk
  task automatic t_cal;
    cal <= 1'b1;
    cyc(1);
    cal <= 1'b0;
    cyc(2);
    chk(busy, 1'b1);
    for (int k = 0; k < 400 && busy !== 1'b0; k++) cyc(1);
    cyc(1);
    chk(ccnt > 24'h00005C && ccnt < 24'h000062, 1'b1);
  endtask : t_cal
  task automatic t_wdt;
    wen <= 1'b1;
    repeat (8) begin
      wsrv <= 1'b1;
      cyc(1);
      wsrv <= 1'b0;
      cyc(40);
    end
    chk({cause, srst_n}, 4'h1);
    for (int k = 0; k < 300 && cause[0] !== 1'b1; k++) cyc(1);
    cyc(2);
    chk({cause[0], srst_n}, 2'h2);
    wen <= 1'b0;
    cyc(30);
    chk(srst_n, 1'b1);
    clear_cause();
    chk(cause, 3'h0);
  endtask : t_wdt
  task automatic t_rst(input bit use_pin, input logic [2:0] bitv);
    if (use_pin) pin_low <= 1'b1;
    else brown <= 1'b1;
    cyc(5);
    chk({srst_n, cause}, {1'b0, bitv});
    pin_low <= 1'b0;
    brown <= 1'b0;
    cyc(20);
    chk(srst_n, 1'b1);
    clear_cause();
  endtask : t_rst
  task automatic t_drop;
    thr <= 4'h9;
    below <= 1'b1;
    cyc(5);
    chk({irq, srst_n, thr_o, cause}, 9'h1C8);
    below <= 1'b0;
    ack <= 1'b1;
    cyc(5);
    ack <= 1'b0;
    cyc(2);
    chk(irq, 1'b0);
  endtask : t_drop
  initial begin
    {nrst_i, pin_low, sstab, crdy, brown, below, ack, cal, wen, wsrv, cclr, slp} <= 12'h000;
    {sel, pre, den, dint, thr} <= '0;
    mhz <= 6'h18;
    cyc(4);
    nrst_i <= 1'b1;
    cyc(2);
    t_por();
    t_freq();
    t_switch();
    t_clk();
    t_cal();
    t_wdt();
    t_rst(1'b1, 3'h4);
    t_rst(1'b0, 3'h2);
    t_drop();
    tally_and_finish();
  end
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
